// ---- hdl/crw_defines.vh ----
// constants for the clock, reset and watchdog controller
`ifndef CRW_DEFINES_VH
`define CRW_DEFINES_VH
`define CRW_SRC_MAIN 3'h0
`define CRW_SRC_LOWSPD 3'h1
`define CRW_SRC_FASTXTAL 3'h2
`define CRW_SRC_WATCH 3'h3
`define CRW_SRC_PIN 3'h4
`define CRW_OSC_RESET_MHZ 6'h18
`define CRW_OSC_MIN_MHZ 6'h03
`define CRW_OSC_MAX_MHZ 6'h30
`define CRW_OSC_FLASH_MHZ 6'h30
`define CRW_FLASH_ROW_MS 20
`define CRW_CLK_MHZ 200
`define CRW_FLASH_ROW_CYC (`CRW_FLASH_ROW_MS * 1000 * `CRW_CLK_MHZ)
`define CRW_NUM_DIV 12
`define CRW_NUM_FRAC_DIV 2
`define CRW_NUM_PCLK 16
`define CRW_CAUSE_WDOG 0
`define CRW_CAUSE_SOFT 1
`define CRW_CAUSE_EXT 2
`define CRW_CAUSE_BROWN 3
`define CRW_MODE_ACTIVE 3'h0
`define CRW_MODE_SLEEP 3'h1
`define CRW_MODE_DEEP 3'h2
`define CRW_MODE_HIBER 3'h3
`define CRW_MODE_STOP 3'h4
`endif

// ---- hdl/crw_divider.v ----
// one peripheral clock divider with optional half step
`timescale 1ns/1ps
module crw_divider #(
   parameter FRAC = 0
)
(
   input wire clk_sys,
   input wire rst,
   input wire enable,
   input wire [15:0] div_val,
   input wire half_step,
   output reg tick_q,
   output reg lead_q
);
   reg [16:0] cnt_q;
   reg [15:0] cur_val_q;
   reg cur_half_q;
   reg phase_q;
   wire [16:0] limit;
   wire wrap;
   // half step: alternate periods are one cycle longer
   assign limit = {1'b0, cur_val_q} + {16'h0000, (FRAC != 0) & cur_half_q & phase_q};
   assign wrap = (cnt_q >= limit);
   always @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         cnt_q <= 17'h00000;
         cur_val_q <= 16'h0000;
         cur_half_q <= 1'b0;
         phase_q <= 1'b0;
         tick_q <= 1'b0;
         lead_q <= 1'b0;
      end
      else if (!enable)
      begin
         cnt_q <= 17'h00000;
         tick_q <= 1'b0;
         lead_q <= 1'b0;
         cur_val_q <= div_val;
         cur_half_q <= half_step;
      end
      else
      begin
         // analog lead pulse one cycle before the digital tick
         lead_q <= (cnt_q + 17'h00001 >= limit) & ~wrap;
         tick_q <= wrap;
         if (wrap)
         begin
            cnt_q <= 17'h00000;
            phase_q <= ~phase_q;
            cur_val_q <= div_val;
            cur_half_q <= half_step;
         end
         else
            cnt_q <= cnt_q + 17'h00001;
      end
   end
endmodule

// ---- hdl/crw_clock_reset_ctrl.v ----
// clock select, oscillator control, dividers, watchdog, reset cause and power modes
`timescale 1ns/1ps
`include "crw_defines.vh"
module crw_clock_reset_ctrl #(
   parameter DIV_W = 16,
   parameter TRIM_W = 8,
   parameter WDOG_W = 16,
   parameter FLASH_ROW_CYC = `CRW_FLASH_ROW_CYC
)
(
   input wire clk_sys,
   input wire rst,
   input wire por_n,
   input wire [4:0] src_clk_in,
   input wire [2:0] src_sel,
   input wire [5:0] osc_freq_mhz,
   input wire flash_busy,
   input wire [TRIM_W-1:0] nvl_trim,
   input wire [TRIM_W-1:0] flash_trim,
   input wire flash_trim_use,
   input wire wdog_enable,
   input wire wdog_src_watch,
   input wire [WDOG_W-1:0] wdog_timeout,
   input wire wdog_service,
   input wire soft_reset_req,
   input wire external_reset_input_n,
   input wire brownout_reset,
   input wire supply_ok,
   input wire [7:0] lvd_level,
   input wire [7:0] supply_level,
   input wire cause_clear,
   input wire [2:0] mode_req,
   input wire wake_event,
   input wire [`CRW_NUM_DIV-1:0] div_enable,
   input wire [`CRW_NUM_DIV*DIV_W-1:0] div_values,
   input wire [`CRW_NUM_FRAC_DIV-1:0] div_half,
   input wire [`CRW_NUM_PCLK*4-1:0] pclk_map,
   output reg [4:0] src_gate_q,
   output reg [2:0] src_active_q,
   output reg [5:0] osc_freq_q,
   output reg [TRIM_W-1:0] osc_trim_q,
   output reg flash_timeout_q,
   output reg sys_reset_q,
   output reg [3:0] reset_cause_q,
   output reg low_voltage_interrupt_q,
   output reg [2:0] power_mode_q,
   output reg [`CRW_NUM_PCLK-1:0] pclk_tick_q,
   output reg [`CRW_NUM_PCLK-1:0] pclk_lead_q
);
   localparam SW_IDLE = 2'h0;
   localparam SW_WAIT_OFF = 2'h1;
   localparam SW_WAIT_ON = 2'h2;
   // synchronisers for pins and foreign clocks
   reg [4:0] src_s1_q;
   reg [4:0] src_s2_q;
   reg external_reset_input_s1_q;
   reg external_reset_input_s2_q;
   reg bod_s1_q;
   reg bod_s2_q;
   reg sok_s1_q;
   reg sok_s2_q;
   reg [1:0] sw_state_q;
   reg [2:0] sw_target_q;
   reg [5:0] osc_user_q;
   reg [31:0] flash_cnt_q;
   reg trim_loaded_q;
   reg wclk_prev_q;
   reg [WDOG_W-1:0] wdog_cnt_q;
   reg wdog_fire_q;
   reg wsel_prev_q;
   reg wake_s1_q;
   reg wake_s2_q;
   reg por_s1_q;
   reg por_s2_q;
   wire [`CRW_NUM_DIV-1:0] div_tick;
   wire [`CRW_NUM_DIV-1:0] div_lead;
   wire wclk_now;
   wire wdog_tick;
   wire int_reset_req;
   wire [3:0] cause_now;
   always @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         src_s1_q <= 5'h00;
         src_s2_q <= 5'h00;
         external_reset_input_s1_q <= 1'b1;
         external_reset_input_s2_q <= 1'b1;
         bod_s1_q <= 1'b0;
         bod_s2_q <= 1'b0;
         sok_s1_q <= 1'b0;
         sok_s2_q <= 1'b0;
         wake_s1_q <= 1'b0;
         wake_s2_q <= 1'b0;
      end
      else
      begin
         src_s1_q <= src_clk_in;
         src_s2_q <= src_s1_q;
         external_reset_input_s1_q <= external_reset_input_n;
         external_reset_input_s2_q <= external_reset_input_s1_q;
         bod_s1_q <= brownout_reset;
         bod_s2_q <= bod_s1_q;
         sok_s1_q <= supply_ok;
         sok_s2_q <= sok_s1_q;
         // wake events come from pins and comparators
         wake_s1_q <= wake_event;
         wake_s2_q <= wake_s1_q;
      end
   end
   // glitch-free switch: drop old gate while its clock is low, then raise new gate while low
   always @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         sw_state_q <= SW_IDLE;
         sw_target_q <= `CRW_SRC_MAIN;
         src_active_q <= `CRW_SRC_MAIN;
         src_gate_q <= 5'h01;
      end
      else
      begin
         case (sw_state_q)
            SW_IDLE:
            begin
               // a request made during a switch waits until idle
               if (src_sel != src_active_q && src_sel <= `CRW_SRC_PIN)
               begin
                  sw_target_q <= src_sel;
                  sw_state_q <= SW_WAIT_OFF;
               end
            end
            SW_WAIT_OFF:
            begin
               if (!src_s2_q[src_active_q])
               begin
                  src_gate_q <= 5'h00;
                  sw_state_q <= SW_WAIT_ON;
               end
            end
            SW_WAIT_ON:
            begin
               if (!src_s2_q[sw_target_q])
               begin
                  src_gate_q <= 5'h01 << sw_target_q;
                  src_active_q <= sw_target_q;
                  sw_state_q <= SW_IDLE;
               end
            end
            default:
               sw_state_q <= SW_IDLE;
         endcase
      end
   end
   // oscillator frequency, flash override and trim
   always @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         osc_user_q <= `CRW_OSC_RESET_MHZ;
         osc_freq_q <= `CRW_OSC_RESET_MHZ;
         flash_cnt_q <= 32'h00000000;
         flash_timeout_q <= 1'b0;
         trim_loaded_q <= 1'b0;
         osc_trim_q <= {TRIM_W{1'b0}};
      end
      else
      begin
         if (osc_freq_mhz >= `CRW_OSC_MIN_MHZ && osc_freq_mhz <= `CRW_OSC_MAX_MHZ)
            osc_user_q <= osc_freq_mhz;
         if (flash_busy)
         begin
            osc_freq_q <= `CRW_OSC_FLASH_MHZ;
            if (flash_cnt_q < FLASH_ROW_CYC)
               flash_cnt_q <= flash_cnt_q + 32'h00000001;
            else
               flash_timeout_q <= 1'b1;
         end
         else
         begin
            osc_freq_q <= osc_user_q;
            flash_cnt_q <= 32'h00000000;
            flash_timeout_q <= 1'b0;
         end
         if (!trim_loaded_q)
         begin
            osc_trim_q <= nvl_trim;
            trim_loaded_q <= 1'b1;
         end
         else if (flash_trim_use)
            osc_trim_q <= flash_trim;
      end
   end
   // watchdog clocked by rising edges of the selected slow source
   assign wclk_now = wdog_src_watch ? src_s2_q[`CRW_SRC_WATCH] : src_s2_q[`CRW_SRC_LOWSPD];
   // no tick on the cycle the source select flips: the two clocks differ in level
   assign wdog_tick = wclk_now & ~wclk_prev_q & (wsel_prev_q == wdog_src_watch);
   always @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         wclk_prev_q <= 1'b0;
         wsel_prev_q <= 1'b0;
         wdog_cnt_q <= {WDOG_W{1'b0}};
         wdog_fire_q <= 1'b0;
      end
      else
      begin
         wclk_prev_q <= wclk_now;
         wsel_prev_q <= wdog_src_watch;
         wdog_fire_q <= 1'b0;
         if (!wdog_enable || wdog_service)
            wdog_cnt_q <= {WDOG_W{1'b0}};
         else if (wdog_tick)
         begin
            // keeps counting in every power mode
            if (wdog_cnt_q + 1'b1 >= wdog_timeout)
            begin
               wdog_fire_q <= 1'b1;
               wdog_cnt_q <= {WDOG_W{1'b0}};
            end
            else
               wdog_cnt_q <= wdog_cnt_q + 1'b1;
         end
      end
   end
   // reset request and its cause
   assign int_reset_req = wdog_fire_q | soft_reset_req | ~external_reset_input_s2_q | bod_s2_q;
   // cause taken straight from the requests, before sys_reset_q can loop back into rst
   assign cause_now = {bod_s2_q, ~external_reset_input_s2_q, soft_reset_req, wdog_fire_q};
   always @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         sys_reset_q <= 1'b1;
      end
      else
      begin
         sys_reset_q <= int_reset_req;
      end
   end
   // cause record: cleared by power-on or cause_clear, never by the resets it logs
   always @(posedge clk_sys or negedge por_n)
   begin
      if (!por_n)
      begin
         por_s1_q <= 1'b0;
         por_s2_q <= 1'b0;
         reset_cause_q <= 4'h0;
      end
      else
      begin
         por_s1_q <= 1'b1;
         por_s2_q <= por_s1_q;
         // set wins over clear; nothing logged until power-on release has settled
         if (por_s2_q)
         begin
            reset_cause_q <= (cause_clear ? 4'h0 : reset_cause_q) | cause_now;
         end
      end
   end
   // power modes and low voltage flag
   always @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         power_mode_q <= `CRW_MODE_ACTIVE;
         low_voltage_interrupt_q <= 1'b0;
      end
      else
      begin
         low_voltage_interrupt_q <= (supply_level <= lvd_level);
         if (power_mode_q != `CRW_MODE_ACTIVE)
         begin
            if (wake_s2_q)
               power_mode_q <= `CRW_MODE_ACTIVE;
         end
         else if (mode_req != `CRW_MODE_ACTIVE && mode_req <= `CRW_MODE_STOP && sok_s2_q)
            power_mode_q <= mode_req;
      end
   end
   genvar gi;
   generate
      for (gi = 0; gi < `CRW_NUM_DIV; gi = gi + 1)
      begin : g_div
         crw_divider #(
            .FRAC(gi >= `CRW_NUM_DIV - `CRW_NUM_FRAC_DIV)
         ) u_div (
            .clk_sys(clk_sys),
            .rst(rst),
            .enable(div_enable[gi]),
            .div_val(div_values[gi*DIV_W +: DIV_W]),
            .half_step((gi >= `CRW_NUM_DIV - `CRW_NUM_FRAC_DIV) ? div_half[gi % `CRW_NUM_FRAC_DIV] : 1'b0),
            .tick_q(div_tick[gi]),
            .lead_q(div_lead[gi])
         );
      end
      for (gi = 0; gi < `CRW_NUM_PCLK; gi = gi + 1)
      begin : g_pclk
         wire [3:0] map_idx;
         wire map_ok;
         wire [3:0] map_sel;
         // codes above 11 stay idle; select clamped to stay in range
         assign map_idx = pclk_map[gi*4 +: 4];
         assign map_ok = (map_idx < `CRW_NUM_DIV);
         assign map_sel = map_ok ? map_idx : 4'h0;
         always @(posedge clk_sys or posedge rst)
         begin
            if (rst)
            begin
               pclk_tick_q[gi] <= 1'b0;
               pclk_lead_q[gi] <= 1'b0;
            end
            else
            begin
               pclk_tick_q[gi] <= map_ok & div_tick[map_sel];
               pclk_lead_q[gi] <= map_ok & div_lead[map_sel];
            end
         end
      end
   endgenerate
endmodule

// ---- verif/crw_chk_assertions.sv ----
// port-level assertions for the clock, reset and watchdog controller
`timescale 1ns/1ps
module crw_chk
(
   input wire clk_sys,
   input wire rst,
   input wire por_n,
   input wire [4:0] src_gate_q,
   input wire [5:0] osc_freq_q,
   input wire flash_busy,
   input wire [15:0] pclk_lead_q,
   input wire [15:0] pclk_tick_q,
   input wire soft_reset_req,
   input wire sys_reset_q,
   input wire [3:0] reset_cause_q,
   input wire cause_clear,
   input wire [7:0] supply_level,
   input wire [7:0] lvd_level,
   input wire low_voltage_interrupt_q
);
   // reset asserted, then the soft bit recorded
   sequence s_soft;
      sys_reset_q ##[0:2] reset_cause_q[1];
   endsequence
   a_gate_onehot:
      assert property (@(posedge clk_sys) disable iff (rst) $onehot0(src_gate_q)) else $error("gates overlap");
   a_freq_range:
      assert property (@(posedge clk_sys) disable iff (rst) osc_freq_q >= 6'h03 && osc_freq_q <= 6'h30)
      else $error("freq range");
   a_flash_fast:
      assert property (@(posedge clk_sys) disable iff (rst) flash_busy |=> osc_freq_q == 6'h30) else $error("flash freq");
   a_lead_tick:
      assert property (@(posedge clk_sys) disable iff (rst) pclk_lead_q != 16'h0 |=> pclk_tick_q == $past(pclk_lead_q))
      else $error("lead without tick");
   a_soft_reset:
      assert property (@(posedge clk_sys) disable iff (rst) soft_reset_req |=> sys_reset_q) else $error("soft reset");
   a_soft_cause:
      assert property (@(posedge clk_sys) disable iff (!por_n) soft_reset_req |=> s_soft) else $error("soft cause");
   a_cause_sticky:
      assert property (@(posedge clk_sys) disable iff (!por_n)
         !cause_clear |=> (reset_cause_q & $past(reset_cause_q)) == $past(reset_cause_q)) else $error("cause lost");
   a_low_volt:
      assert property (@(posedge clk_sys) disable iff (rst)
         1'b1 |=> low_voltage_interrupt_q == ($past(supply_level) <= $past(lvd_level))) else $error("low voltage");
   a_rst_state:
      assert property (@(posedge clk_sys) rst |=> sys_reset_q && osc_freq_q == 6'h18) else $error("reset state");
endmodule
bind crw_clock_reset_ctrl crw_chk u_chk (.clk_sys(clk_sys), .rst(rst), .por_n(por_n), .src_gate_q(src_gate_q),
   .osc_freq_q(osc_freq_q), .flash_busy(flash_busy), .pclk_lead_q(pclk_lead_q), .pclk_tick_q(pclk_tick_q),
   .soft_reset_req(soft_reset_req), .sys_reset_q(sys_reset_q), .reset_cause_q(reset_cause_q),
   .cause_clear(cause_clear), .supply_level(supply_level), .lvd_level(lvd_level),
   .low_voltage_interrupt_q(low_voltage_interrupt_q));

// ---- verif/tb_clock_reset_watchdog_ctrl.sv ----
// self-checking testbench for the clock, reset and watchdog controller
`timescale 1ns/1ps
module tb_clock_reset_watchdog_ctrl;
   logic clk_sys = 0, rst = 1, por_n = 0, flash_busy = 0, flash_trim_use = 0, wdog_enable = 0;
   logic wdog_src_watch = 0, wdog_service = 0, soft_reset_req = 0, external_reset_input_n = 1;
   logic brownout_reset = 0, supply_ok = 1, cause_clear = 0, wake_event = 0;
   logic [4:0] src_clk_in = 5'h00;
   logic [2:0] src_sel = 3'h0, mode_req = 3'h0;
   logic [5:0] osc_freq_mhz = 6'h18;
   logic [7:0] nvl_trim = 8'h5a, flash_trim = 8'ha5, lvd_level = 8'h40, supply_level = 8'h80;
   logic [15:0] wdog_timeout = 16'h0004;
   logic [11:0] div_enable = 12'h000;
   logic [191:0] div_values = 192'h0;
   logic [1:0] div_half = 2'h0;
   logic [63:0] pclk_map = 64'hffffffffffffffff;
   logic [4:0] src_gate_q;
   logic [2:0] src_active_q, power_mode_q;
   logic [5:0] osc_freq_q;
   logic [7:0] osc_trim_q;
   logic flash_timeout_q, sys_reset_q, low_voltage_interrupt_q;
   logic [3:0] reset_cause_q;
   logic [15:0] pclk_tick_q, pclk_lead_q;
   int num_errors = 0, n_tests = 0, cyc = 0, k, a, b;
   crw_clock_reset_ctrl #(.FLASH_ROW_CYC(50)) DUT (.clk_sys(clk_sys), .rst(rst), .por_n(por_n),
      .src_clk_in(src_clk_in), .src_sel(src_sel), .osc_freq_mhz(osc_freq_mhz), .flash_busy(flash_busy),
      .nvl_trim(nvl_trim), .flash_trim(flash_trim), .flash_trim_use(flash_trim_use), .wdog_enable(wdog_enable),
      .wdog_src_watch(wdog_src_watch), .wdog_timeout(wdog_timeout), .wdog_service(wdog_service),
      .soft_reset_req(soft_reset_req), .external_reset_input_n(external_reset_input_n),
      .brownout_reset(brownout_reset), .supply_ok(supply_ok), .lvd_level(lvd_level),
      .supply_level(supply_level), .cause_clear(cause_clear), .mode_req(mode_req), .wake_event(wake_event),
      .div_enable(div_enable), .div_values(div_values), .div_half(div_half), .pclk_map(pclk_map),
      .src_gate_q(src_gate_q), .src_active_q(src_active_q), .osc_freq_q(osc_freq_q), .osc_trim_q(osc_trim_q),
      .flash_timeout_q(flash_timeout_q), .sys_reset_q(sys_reset_q), .reset_cause_q(reset_cause_q),
      .low_voltage_interrupt_q(low_voltage_interrupt_q), .power_mode_q(power_mode_q),
      .pclk_tick_q(pclk_tick_q), .pclk_lead_q(pclk_lead_q));
   initial
   begin
      forever #2.5 clk_sys = ~clk_sys;
   end
   // free-running source clocks, slower with each bit
   always @(posedge clk_sys) src_clk_in <= #1 src_clk_in + 5'h01;
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         num_errors++;
         complete_run;
      end
   end
   task complete_run;
      if (num_errors == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input [15:0] g, input [15:0] e);
      n_tests++;
      if (g !== e)
      begin
         $display("BAD %0t %h %h", $time, g, e);
         num_errors++;
      end
   endtask
   task step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task pulse_clear;
      cause_clear = 1;
      step(1);
      cause_clear = 0;
   endtask
   task t_reset;
      step(1);
      chk(osc_freq_q, 6'h18);
      chk(src_gate_q, 5'h01);
      chk(sys_reset_q, 1'b1);
      step(1);
      rst = 0;
      por_n = 1;
      step(3);
      chk(osc_trim_q, 8'h5a);
      chk(sys_reset_q, 1'b0);
      flash_trim_use = 1;
      step(2);
      chk(osc_trim_q, 8'ha5);
   endtask
   task t_osc;
      logic [5:0] v[4];
      logic [5:0] e[4];
      v = '{6'h03, 6'h02, 6'h30, 6'h31};
      e = '{6'h03, 6'h03, 6'h30, 6'h30};
      for (int i = 0; i < 4; i++)
      begin
         osc_freq_mhz = v[i];
         step(2);
         chk(osc_freq_q, e[i]);
      end
   endtask
   task t_src;
      for (int i = 2; i < 5; i++)
      begin
         src_sel = 3'(i);
         for (k = 0; k < 300 && src_active_q !== 3'(i); k++) step(1);
         chk(src_active_q, 16'(i));
         chk(src_gate_q, 5'h01 << i);
      end
      src_sel = 3'h7;
      step(40);
      chk(src_active_q, 3'h4);
      src_sel = 3'h0;
      for (k = 0; k < 300 && src_active_q !== 3'h0; k++) step(1);
      chk(src_gate_q, 5'h01);
   endtask
   task t_flash;
      osc_freq_mhz = 6'h0a;
      step(2);
      flash_busy = 1;
      step(2);
      chk(osc_freq_q, 6'h30);
      chk(flash_timeout_q, 1'b0);
      step(52);
      chk(flash_timeout_q, 1'b1);
      flash_busy = 0;
      step(2);
      chk(osc_freq_q, 6'h0a);
   endtask
   task t_wdog;
      wdog_enable = 1;
      for (k = 0; k < 40; k++)
      begin
         wdog_service = 1;
         step(1);
         wdog_service = 0;
         step(1);
      end
      chk(sys_reset_q, 1'b0);
      chk(reset_cause_q, 4'h0);
      wdog_enable = 0;
      step(1);
      for (int w = 0; w < 2; w++)
      begin
         wdog_src_watch = w[0];
         pulse_clear;
         wdog_enable = 1;
         for (a = 0; a < 300 && sys_reset_q !== 1'b1; a++) step(1);
         step(2);
         chk(a > 40, 16'(w));
         chk(reset_cause_q, 4'h1);
         wdog_enable = 0;
         rst = 1;
         step(2);
         rst = 0;
         step(3);
         chk(reset_cause_q, 4'h1);
      end
   endtask
   task t_cause;
      for (int i = 1; i < 4; i++)
      begin
         pulse_clear;
         soft_reset_req = (i == 1);
         external_reset_input_n = (i != 2);
         brownout_reset = (i == 3);
         step(3);
         soft_reset_req = 0;
         external_reset_input_n = 1;
         brownout_reset = 0;
         step(5);
         chk(reset_cause_q, 4'h1 << i);
         chk(sys_reset_q, 1'b0);
      end
      supply_level = 8'h40;
      step(2);
      chk(low_voltage_interrupt_q, 1'b1);
      supply_level = 8'h41;
      step(2);
      chk(low_voltage_interrupt_q, 1'b0);
   endtask
   task t_mode;
      for (int m = 1; m < 5; m++)
      begin
         mode_req = 3'(m);
         step(5);
         chk(power_mode_q, 16'(m));
         mode_req = 3'h0;
         wake_event = 1;
         step(1);
         wake_event = 0;
         step(3);
         chk(power_mode_q, 3'h0);
      end
      supply_ok = 0;
      step(3);
      mode_req = 3'h1;
      step(6);
      chk(power_mode_q, 3'h0);
      supply_ok = 1;
      step(4);
      chk(power_mode_q, 3'h1);
      mode_req = 3'h0;
      wake_event = 1;
      step(1);
      wake_event = 0;
      step(3);
   endtask
   task gap(input int o, output int g);
      for (k = 0; k < 50 && pclk_tick_q[o] !== 1'b1; k++) step(1);
      step(1);
      for (g = 1; g < 50 && pclk_tick_q[o] !== 1'b1; g++) step(1);
   endtask
   task t_div;
      div_values[15:0] = 16'h0003;
      div_values[175:160] = 16'h0001;
      div_half = 2'b01;
      pclk_map[7:0] = 8'ha0;
      div_enable = 12'h401;
      gap(0, a);
      chk(a, 4);
      div_values[15:0] = 16'h0007;
      gap(0, a);
      gap(0, b);
      chk(a, 4);
      chk(b, 8);
      gap(1, a);
      gap(1, b);
      chk(a + b, 5);
   endtask
   initial
   begin
      t_reset;
      t_osc;
      t_src;
      t_flash;
      t_wdog;
      t_cause;
      t_mode;
      t_div;
      complete_run;
   end
endmodule
